// ### core/uart_baud_rate_generator.sv
// Baud rate generator with Wishbone registers and receive majority sampler
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/10ps
`include "baud_gen_params.svh"
module uart_baud_rate_generator (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_pin_i,
  input wire logic ext_clk_i,
  output logic baud_tick_o,
  output logic rx_level_o,
  output logic port_enable_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] tx_control_status_r;
  logic [7:0] rx_control_status_r;
  logic [7:0] baud_control_r;
  logic [7:0] baud_divisor_high_r;
  logic [7:0] baud_divisor_low_r;

  // Bus request decode
  logic wb_req;
  logic wr_en;
  logic div_wr;

  // Divider mode, counters and ratio
  baud_gen_pkg::mode_t mode;
  logic [5:0] pre_cnt_r;
  logic [5:0] pre_max;
  logic [15:0] div_cnt_r;
  logic [15:0] divide_n;
  logic serial_port_enable;

  // Pin synchronisers; only the second stage reads the first
  logic rx_s1_r, rx_s2_r, rx_s3_r, rx_s4_r;
  logic ext_s1_r, ext_s2_r, ext_s3_r;

  // Divider wrap and internal tick
  logic pre_wrap;
  logic internal_tick;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  // Both divisor bytes share the restart path, so they decode as one
  function automatic logic is_divisor_adr(input logic [3:0] adr);
    is_divisor_adr = (adr == `ADR_DIV_HIGH) || (adr == `ADR_DIV_LOW);
  endfunction

  // Majority of three; one disagreeing sample is outvoted
  function automatic logic vote3(input logic a, input logic b, input logic c);
    vote3 = (a & b) | (a & c) | (b & c);
  endfunction

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = wb_req & wb_we_i & wb_sel_i[0] & ce_i;
  // Either divisor byte written restarts the count
  assign div_wr = wr_en & is_divisor_adr(wb_adr_i);
  assign serial_port_enable = rx_control_status_r[`BIT_PORT_EN];
  assign port_enable_o = serial_port_enable;

  // Read-only bits are rebuilt from constants, never taken from the bus
  // Register writes; reserved bits of baud control stay zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_control_status_r <= `RST_TX_CTRL;
      rx_control_status_r <= `RST_RX_CTRL;
      baud_control_r <= `RST_BAUD_CTRL;
      baud_divisor_high_r <= `RST_DIV;
      baud_divisor_low_r <= `RST_DIV;
    end else if (wr_en) begin
      if (wb_adr_i == `ADR_TX_CTRL) begin
        tx_control_status_r <= {wb_dat_i[7:2], 1'b1, wb_dat_i[0]};
      end else if (wb_adr_i == `ADR_RX_CTRL) begin
        rx_control_status_r <= {wb_dat_i[7:3], 3'b000};
      end else if (wb_adr_i == `ADR_BAUD_CTRL) begin
        baud_control_r <= {2'b01, 1'b0, wb_dat_i[4:3], 1'b0, wb_dat_i[1:0]};
      end else if (wb_adr_i == `ADR_DIV_HIGH) begin
        baud_divisor_high_r <= wb_dat_i[7:0];
      end else if (wb_adr_i == `ADR_DIV_LOW) begin
        baud_divisor_low_r <= wb_dat_i[7:0];
      end
    end
  end

  // Data is registered every clock-enabled cycle, so it stands in the ack cycle
  // Ack one cycle after request; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      if (wb_adr_i == `ADR_TX_CTRL) begin
        wb_dat_o <= {24'h000000, tx_control_status_r};
      end else if (wb_adr_i == `ADR_RX_CTRL) begin
        wb_dat_o <= {24'h000000, rx_control_status_r};
      end else if (wb_adr_i == `ADR_BAUD_CTRL) begin
        wb_dat_o <= {24'h000000, baud_control_r};
      end else if (wb_adr_i == `ADR_DIV_HIGH) begin
        wb_dat_o <= {24'h000000, baud_divisor_high_r};
      end else if (wb_adr_i == `ADR_DIV_LOW) begin
        wb_dat_o <= {24'h000000, baud_divisor_low_r};
      end else if (wb_adr_i == `ADR_STATUS) begin
        wb_dat_o <= {16'h0000, div_cnt_r};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  assign mode.sync_mode = tx_control_status_r[`BIT_SYNC];
  assign mode.width_sel = baud_control_r[`BIT_WIDTH_SEL];
  assign mode.high_speed = tx_control_status_r[`BIT_HIGH_SPEED];
  assign mode.clk_master = tx_control_status_r[`BIT_CLK_SRC];

  // High byte ignored in 8-bit mode
  assign divide_n = mode.width_sel ? {baud_divisor_high_r, baud_divisor_low_r}
                                   : {8'h00, baud_divisor_low_r};

  // Prescale picks the fixed part of the ratio
  always_comb begin
    pre_max = `PRE_64;
    if (mode.sync_mode) begin
      pre_max = `PRE_4;
    end else if (!mode.width_sel && !mode.high_speed) begin
      pre_max = `PRE_64;
    end else if (mode.width_sel && !mode.high_speed) begin
      pre_max = `PRE_16;
    end else if (!mode.width_sel) begin
      pre_max = `PRE_16;
    end else begin
      pre_max = `PRE_4;
    end
  end

  // Greater-or-equal, so a switch to a shorter ratio cannot overrun
  assign pre_wrap = (pre_cnt_r >= pre_max);

  // Port disable holds the divider cleared, like a fresh enable
  // Runs on the device clock itself, so rate tracks the active source
  always_ff @(posedge clk_i) begin
    if (rst_i || !serial_port_enable || div_wr) begin
      pre_cnt_r <= 6'h00;
      div_cnt_r <= 16'h0000;
    end else if (ce_i) begin
      if (pre_wrap) begin
        pre_cnt_r <= 6'h00;
        if (div_cnt_r >= divide_n) begin
          div_cnt_r <= 16'h0000;
        end else begin
          div_cnt_r <= div_cnt_r + 16'h0001;
        end
      end else begin
        pre_cnt_r <= pre_cnt_r + 6'h01;
      end
    end
  end

  // Tick on the last prescale clock of the last divide step
  assign internal_tick = pre_wrap && (div_cnt_r >= divide_n);

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  // Two-flop sync then three samples for the vote
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_s4_r <= 1'b1;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else if (ce_i) begin
      rx_s1_r <= rx_pin_i;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      rx_s4_r <= rx_s3_r;
      ext_s1_r <= ext_clk_i;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // Majority of three: one glitchy sample cannot flip the level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_level_o <= 1'b1;
    end else if (ce_i) begin
      rx_level_o <= vote3(rx_s2_r, rx_s3_r, rx_s4_r);
    end
  end

  // Slave mode ticks on external rising edge instead of the divider
  always_ff @(posedge clk_i) begin
    if (rst_i || !serial_port_enable) begin
      baud_tick_o <= 1'b0;
    end else if (ce_i) begin
      if (mode.sync_mode && !mode.clk_master) begin
        baud_tick_o <= ext_s2_r & ~ext_s3_r;
      end else begin
        baud_tick_o <= internal_tick;
      end
    end else begin
      // A frozen pulse must not be counted as many bit periods
      baud_tick_o <= 1'b0;
    end
  end
endmodule

// ### core/baud_gen_params.svh
// Constants for the baud rate generator and receive sampler
// What this block does
// - Divider counts on the device clock, so rate follows the active clock.
// - Receive level is decided by majority vote of three samples.
// - Async, 8-bit, low speed: rate is clock over 64 times (n+1).
// - Async, 16-bit, low speed: rate is clock over 16 times (n+1).
// - Sync mode, either width: clock over 4 times (n+1), speed select ignored.
// - n is high divisor byte concatenated above low divisor byte.
// - Writing either divisor byte clears the divider counter at once.
// - Width select cleared, the default, uses only the low divisor byte.
// - Formulas apply to internal clock; sync slave takes the external clock.
`ifndef BAUD_GEN_PARAMS_SVH
`define BAUD_GEN_PARAMS_SVH
`define ADR_TX_CTRL 4'h0
`define ADR_RX_CTRL 4'h1
`define ADR_BAUD_CTRL 4'h2
`define ADR_DIV_HIGH 4'h3
`define ADR_DIV_LOW 4'h4
`define ADR_STATUS 4'h5
`define BIT_CLK_SRC 7
`define BIT_SYNC 4
`define BIT_HIGH_SPEED 2
`define BIT_PORT_EN 7
`define BIT_WIDTH_SEL 3
`define RST_TX_CTRL 8'h02
`define RST_RX_CTRL 8'h00
`define RST_BAUD_CTRL 8'h40
`define RST_DIV 8'h00
`define PRE_64 6'h3F
`define PRE_16 6'h0F
`define PRE_4 6'h03
`define PRE_1 6'h00
`endif

// ### core/baud_gen_pkg.sv
// Types shared by the baud rate generator
package baud_gen_pkg;
  typedef struct packed {
    logic sync_mode;
    logic width_sel;
    logic high_speed;
    logic clk_master;
  } mode_t;
endpackage

// ### verification/baud_chk.sv
// Port checks for the baud generator
`timescale 1ns/10ps
module baud_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_ack_o,
  input wire logic rx_pin_i,
  input wire logic rx_level_o,
  input wire logic baud_tick_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answer is one pulse, one cycle late
  ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("long ack");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  // Two low cycles, so a registered tick is covered too
  ce_hold_a: assert property (!ce_i |=> $stable(wb_ack_o) && $stable(rx_level_o)) else $error("moved");
  tick_gate_a: assert property (!ce_i [*2] |-> !baud_tick_o) else $error("tick");
  tick_pulse_a: assert property (baud_tick_o |=> !baud_tick_o [*2]) else $error("wide tick");
  // Old count must not survive a divisor write
  div_clear_a: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i && wb_sel_i[0]
    && wb_adr_i inside {4'h3, 4'h4} |=> ##1 !baud_tick_o [*2]) else $error("old tick");
  rx_vote_a: assert property ($stable(rx_pin_i) [*8] |-> rx_level_o == rx_pin_i) else $error("rx");
  // Main scenarios
  cover property (baud_tick_o);
  cover property (wb_ack_o && wb_we_i);
  cover property ($fell(rx_level_o));
endmodule
bind uart_baud_rate_generator baud_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o),
  .rx_pin_i(rx_pin_i), .rx_level_o(rx_level_o), .baud_tick_o(baud_tick_o));

// ### verification/tb_uart_baud_rate_generator.sv
// Directed bench for the baud generator
`timescale 1ns/10ps
module tb_uart_baud_rate_generator;
  logic clk_i = 0, rst_i = 1, ce = 1, cyc = 0, stb = 0, we = 0, rx = 1, ext = 0, ack, tick, lvl, pen;
  logic [3:0] adr = 4'h0, sel = 4'hF, wsel = 4'hF;
  logic [31:0] wd = 32'h0, rd, d;
  int failures = 0, n_checks = 0, n;
  // Packed tx ctrl, baud ctrl, high, low; periods in clocks
  logic [31:0] tab [6] = '{32'h00000102, 32'h00080003, 32'h04000001, 32'h04080100, 32'h90000005, 32'h94080005};
  int per [6] = '{192, 64, 32, 1028, 24, 24};
  uart_baud_rate_generator uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .rx_pin_i(rx), .ext_clk_i(ext), .baud_tick_o(tick), .rx_level_o(lvl), .port_enable_o(pen));
  initial forever #12.5 clk_i = ~clk_i;
  task chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  // Classic cycle, held until ack is sampled
  task xfer(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    sel <= wsel;
    adr <= a;
    wd <= {24'h0, v};
    do @(posedge clk_i); while (ack !== 1'b1);
    d = rd;
    cyc <= 0;
    stb <= 0;
  endtask
  // Clocks up to the next tick, capped
  task gap;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tick !== 1'b1 && n < 3000);
  endtask
  task end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Longest run is a few thousand clocks
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    xfer(0, 4'h2, 8'h00);
    chk(d, 32'h40);
    xfer(0, 4'h7, 8'h00);
    chk(d, 32'h0);
    chk(32'(pen), 0);
    xfer(1, 4'h1, 8'h80);
    chk(32'(pen), 1);
    // Low byte last, so its write restarts the count
    for (int i = 0; i < 6; i++) begin
      xfer(1, 4'h0, tab[i][31:24]);
      xfer(1, 4'h2, tab[i][23:16]);
      xfer(1, 4'h3, tab[i][15:8]);
      xfer(1, 4'h4, tab[i][7:0]);
      gap;
      chk(32'(n), 32'(per[i]));
      gap;
      chk(32'(n), 32'(per[i]));
    end
    // Read-only bits read back fixed; a write without byte lane 0 is refused
    xfer(0, 4'h0, 8'h00);
    chk(d, 32'h96);
    xfer(0, 4'h2, 8'h00);
    chk(d, 32'h48);
    wsel = 4'hE;
    xfer(1, 4'h4, 8'hAA);
    wsel = 4'hF;
    xfer(0, 4'h4, 8'h00);
    chk(d, 32'h05);
    ce <= 0;
    repeat (30) @(posedge clk_i);
    ce <= 1;
    // Slave mode: tick only from the outside edge
    xfer(1, 4'h0, 8'h10);
    repeat (3) @(posedge clk_i);
    ext <= 1;
    gap;
    chk(32'(n >= 2 && n <= 5), 1);
    ext <= 0;
    // Without outside edges the running divider must not tick
    n = 0;
    repeat (60) begin
      @(posedge clk_i);
      if (tick !== 1'b0) n++;
    end
    chk(32'(n), 0);
    // A one-cycle glitch is outvoted
    rx <= 0;
    @(posedge clk_i);
    rx <= 1;
    repeat (8) begin
      @(posedge clk_i);
      chk(32'(lvl), 1);
    end
    rx <= 0;
    repeat (8) @(posedge clk_i);
    chk(32'(lvl), 0);
    // Port disable holds the divider cleared; status shows the count
    xfer(1, 4'h1, 8'h00);
    chk(32'(pen), 0);
    xfer(0, 4'h5, 8'h00);
    chk(d, 32'h0);
    end_sim;
  end
endmodule
